// [core/aodt_consts.svh]
// Purpose: offsets, field positions, reset values and counts of the output detect/test block
// Assumes: 13-bit serial-port register addresses, one byte per register
// Notes: thresholds are 16-bit values held as low/high byte pairs
`ifndef AODT_CONSTS_SVH
`define AODT_CONSTS_SVH

// register offsets
`define AODT_REG_TEST_MODE 13'h00d
`define AODT_REG_USER_FIRST 13'h019
`define AODT_REG_USER_LAST 13'h020
`define AODT_REG_THR_FIRST 13'h100
`define AODT_REG_THR_LAST 13'h107
`define AODT_REG_CAL_CTRL 13'h108
`define AODT_REG_OUT_FMT 13'h109
`define AODT_REG_STATUS 13'h10a
`define AODT_REG_CAL_COUNT 13'h10b

// threshold pair indices
`define AODT_THR_UPPER 2'h0
`define AODT_THR_LOWER 2'h1
`define AODT_THR_DWELL 2'h2
`define AODT_THR_CAL 2'h3

// reset values and field positions
`define AODT_TEST_MODE_RST 4'h0
`define AODT_CAL_GATE_RST 1'h1
`define AODT_CAL_GATE_BIT 0
`define AODT_OUT_FMT_BIT 0

// serial port framing: last bit index of instruction and data phases
`define AODT_SPI_CMD_LAST 5'h0f
`define AODT_SPI_DATA_LAST 5'h07

// calibration window and scaling of the average estimate
`define AODT_CAL_LAST 10'h3ff
`define AODT_CAL_AVG_SHIFT 7
`define AODT_CAL_FULL 16'h4000

// fixed pattern words
`define AODT_WORD_ZERO 12'h000
`define AODT_WORD_POS 12'h7ff
`define AODT_WORD_NEG 12'h800
`define AODT_WORD_CHK_A 12'haaa
`define AODT_WORD_CHK_B 12'h555
`define AODT_WORD_ONES 12'hfff
`define AODT_PRBS_SEED 23'h7fffff

`endif

// [core/aodt_pkg.sv]
// Purpose: types shared by the output detect/test block
// Assumes: nothing
// Notes: constants live in aodt_consts.svh
package aodt_pkg;
    typedef enum logic [3:0] {
        AODT_SPI_IDLE = 4'b0001,
        AODT_SPI_CMD = 4'b0010,
        AODT_SPI_DATA = 4'b0100,
        AODT_SPI_END = 4'b1000
    } aodt_spi_e;

    typedef enum logic [3:0] {
        AODT_TM_OFF = 4'h0,
        AODT_TM_ZERO = 4'h1,
        AODT_TM_POS = 4'h2,
        AODT_TM_NEG = 4'h3,
        AODT_TM_CHK = 4'h4,
        AODT_TM_PRBS = 4'h5,
        AODT_TM_TOGGLE = 4'h7,
        AODT_TM_USER = 4'h8,
        AODT_TM_RAMP = 4'hf
    } aodt_mode_e;
endpackage : aodt_pkg

// [core/aodt_cfg_if.sv]
// Purpose: configuration and status between the register file and the datapath parts
// Assumes: driven by the top module on the core clock
// Notes: user words are 12-bit, left-justified in their byte pairs
`timescale 1ns/100ps
`default_nettype none
interface aodt_cfg_if;
    logic [3:0] test_mode;
    logic offset_bin;
    logic [11:0] user_word [4];
    logic [15:0] upper_thr;
    logic [15:0] lower_thr;
    logic [15:0] dwell;
    logic over_range_flag;

    modport pat (input test_mode, input offset_bin, input user_word);
    modport fdet (input upper_thr, input lower_thr, input dwell, output over_range_flag);
endinterface : aodt_cfg_if
`default_nettype wire

// [core/aodt_fdet.sv]
// Purpose: over-range flag with upper/lower thresholds and dwell hysteresis
// Assumes: sample is registered on the core clock, twos complement
// Notes: magnitude is scaled by 8 so full scale matches the 0..0x4000 threshold range
`timescale 1ns/100ps
`default_nettype none
module aodt_fdet (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] sample,
    aodt_cfg_if.fdet cfg
);
    logic [11:0] mag;
    logic [15:0] mag16;
    logic above;
    logic below;
    logic flag_q, flag_d;
    logic [15:0] cnt_q, cnt_d;

    // magnitude and threshold compares
    assign mag = sample[11] ? 12'(~sample + 12'h001) : sample;
    assign mag16 = {1'b0, mag, 3'h0};
    assign above = mag16 > cfg.upper_thr;
    assign below = mag16 < cfg.lower_thr;

    // dwell run length and flag decision
    always_comb begin
        cnt_d = below ? ((cnt_q == 16'hffff) ? cnt_q : 16'(cnt_q + 16'h0001)) : 16'h0000;
        flag_d = flag_q;
        if (above) begin
            flag_d = 1'b1;
        end else if (flag_q && below && (cnt_q >= cfg.dwell)) begin
            flag_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
            cnt_q <= 16'h0000;
        end else begin
            flag_q <= flag_d;
            cnt_q <= cnt_d;
        end
    end

    assign cfg.over_range_flag = flag_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence quiet_run;
        below && !above && (cnt_q >= cfg.dwell);
    endsequence

    flag_set_a: assert property (above |=> flag_q)
        else $error("flag not set above upper");
    flag_keep_a: assert property (flag_q && !below |=> flag_q)
        else $error("flag cleared early");
    flag_clear_a: assert property (flag_q ##0 quiet_run |=> !flag_q)
        else $error("flag not cleared");
    clear_cause_a: assert property ($fell(flag_q) |->
        $past(below) && $past(cnt_q) >= $past(cfg.dwell)) else $error("flag cleared without dwell");
endmodule : aodt_fdet
`default_nettype wire

// [core/aodt_pattern.sv]
// Purpose: output word select between converted samples and test patterns
// Assumes: one output word per core clock
// Notes: offset binary conversion flips the sign bit of patterns that take it
`timescale 1ns/100ps
`default_nettype none
`include "aodt_consts.svh"
module aodt_pattern (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] sample,
    aodt_cfg_if.pat cfg,
    output logic [11:0] data_out
);
    logic phase_q, phase_d;
    logic [11:0] ramp_q, ramp_d;
    logic [22:0] prbs_q, prbs_d;
    logic [1:0] uidx_q, uidx_d;
    logic [11:0] data_q, data_d;
    logic [11:0] word;
    logic subj;

    // pattern state and word select
    always_comb begin
        phase_d = ~phase_q;
        prbs_d = {prbs_q[21:0], prbs_q[22] ^ prbs_q[17]};
        ramp_d = 12'h000;
        uidx_d = 2'h0;
        subj = 1'b1;
        case (cfg.test_mode)
            aodt_pkg::AODT_TM_ZERO: word = `AODT_WORD_ZERO;
            aodt_pkg::AODT_TM_POS: word = `AODT_WORD_POS;
            aodt_pkg::AODT_TM_NEG: word = `AODT_WORD_NEG;
            aodt_pkg::AODT_TM_CHK: begin
                word = phase_q ? `AODT_WORD_CHK_B : `AODT_WORD_CHK_A;
                subj = 1'b0;
            end
            aodt_pkg::AODT_TM_PRBS: word = prbs_q[11:0];
            aodt_pkg::AODT_TM_TOGGLE: begin
                word = phase_q ? `AODT_WORD_ZERO : `AODT_WORD_ONES;
                subj = 1'b0;
            end
            aodt_pkg::AODT_TM_USER: begin
                word = cfg.user_word[uidx_q];
                uidx_d = 2'(uidx_q + 2'h1);
            end
            aodt_pkg::AODT_TM_RAMP: begin
                word = ramp_q;
                ramp_d = 12'(ramp_q + 12'h001);
                subj = 1'b0;
            end
            default: word = sample;
        endcase
        data_d = (subj && cfg.offset_bin) ? {~word[11], word[10:0]} : word;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 1'b0;
            ramp_q <= 12'h000;
            prbs_q <= `AODT_PRBS_SEED;
            uidx_q <= 2'h0;
            data_q <= 12'h000;
        end else begin
            phase_q <= phase_d;
            ramp_q <= ramp_d;
            prbs_q <= prbs_d;
            uidx_q <= uidx_d;
            data_q <= data_d;
        end
    end

    assign data_out = data_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence chk_pair;
        (data_q == `AODT_WORD_CHK_A) ##1 (data_q == `AODT_WORD_CHK_B);
    endsequence

    logic chk_run;
    assign chk_run = cfg.test_mode == aodt_pkg::AODT_TM_CHK;

    // the mode must still hold one cycle on, or the second word is legally another pattern
    chk_alt_a: assert property (chk_run [*3] ##0 !phase_q ##1 chk_run |-> chk_pair)
        else $error("checkerboard not alternating");
    ramp_step_a: assert property ($past(cfg.test_mode == aodt_pkg::AODT_TM_RAMP, 2) &&
        $past(cfg.test_mode == aodt_pkg::AODT_TM_RAMP) |-> data_q == 12'($past(data_q) + 12'h001))
        else $error("ramp did not step by one");
    pos_word_a: assert property (cfg.test_mode == aodt_pkg::AODT_TM_POS && !cfg.offset_bin
        |=> data_q == `AODT_WORD_POS) else $error("positive full scale word wrong");
    toggle_a: assert property (cfg.test_mode == aodt_pkg::AODT_TM_TOGGLE [*2]
        |=> data_q != $past(data_q)) else $error("toggle word did not change");
    pass_a: assert property ((cfg.test_mode == 4'h0 || cfg.test_mode == 4'h6) && !cfg.offset_bin
        |=> data_q == $past(sample)) else $error("samples not passed through");
endmodule : aodt_pattern
`default_nettype wire

// [core/aodt_top.sv]
// Purpose: serial-port registers, calibration gate, over-range detect and test output
// Assumes: CORE_CLK is the sample clock; serial-port pins are asynchronous to it
// Notes: single-byte serial transfers: 16-bit instruction then 8 data bits
// Operation
// - register each sample on rising clock edge
// - set over-range flag when magnitude exceeds upper
// - clear flag after below-lower run exceeds dwell
// - accumulate sample magnitudes during calibration window
// - update coefficients only if average exceeds threshold
// - calibration threshold gating enabled after reset
// - 16-bit thresholds assembled from single-byte writes
// - calibration threshold spans zero to 0x4000
// - code 0000 default passes converted samples
// - codes 0001-0011 output fixed words
// - code 0100 alternates checkerboard words
// - code 0101 outputs long pseudo-random sequence
// - code 0111 alternates all ones, all zeros
// - code 1000 outputs user pattern registers
// - code 1111 outputs incrementing ramp
// - format conversion only on listed patterns
`timescale 1ns/100ps
`default_nettype none
`include "aodt_consts.svh"
module aodt_top (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [11:0] SAMPLE_IN,
    input wire logic SPI_CS_N,
    input wire logic SPI_SCLK,
    input wire logic SDIO_I,
    output logic SDIO_O,
    output logic SDIO_OE_N,
    output logic OVER_RANGE_FLAG,
    output logic [11:0] DATA_OUT,
    output logic CAL_UPDATE
);
    aodt_cfg_if cfg ();

    // pin synchronisers; stage one feeds stage two only
    logic cs_m, cs_s, sck_m, sck_s, sck_p, sdi_m, sdi_s;
    logic sck_rise, sck_fall;
    logic [11:0] sample_q;

    // serial port state
    aodt_pkg::aodt_spi_e st_q, st_d;
    logic [4:0] cnt_q, cnt_d;
    logic [15:0] sh_q, sh_d;
    logic [12:0] addr_q, addr_d;
    logic rd_q, rd_d;
    logic [7:0] tx_q, tx_d;
    logic sdo_q, sdo_d, oe_n_q, oe_n_d;
    logic we;
    logic [7:0] wdat;

    // register file
    logic [3:0] tm_q, tm_d;
    logic [7:0] user_q [8];
    logic [7:0] user_d [8];
    logic [15:0] thr_q [4];
    logic [15:0] thr_d [4];
    logic [7:0] pend_q [4];
    logic [7:0] pend_d [4];
    logic gate_q, gate_d, fmt_q, fmt_d;

    // calibration state
    logic [11:0] mag;
    logic [21:0] acc_q, acc_d, acc_sum;
    logic [9:0] ccnt_q, ccnt_d;
    logic [15:0] avg;
    logic upd_q, upd_d, ok_q, ok_d;
    logic [7:0] ucnt_q, ucnt_d;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            sck_m <= 1'b0;
            sck_s <= 1'b0;
            sck_p <= 1'b0;
            sdi_m <= 1'b0;
            sdi_s <= 1'b0;
            sample_q <= 12'h000;
        end else begin
            cs_m <= SPI_CS_N;
            cs_s <= cs_m;
            sck_m <= SPI_SCLK;
            sck_s <= sck_m;
            sck_p <= sck_s;
            sdi_m <= SDIO_I;
            sdi_s <= sdi_m;
            sample_q <= SAMPLE_IN;
        end
    end

    assign sck_rise = sck_s && !sck_p;
    assign sck_fall = !sck_s && sck_p;

    // register read mux
    function automatic logic [7:0] rd_byte(input logic [12:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a == `AODT_REG_TEST_MODE) begin
            r = {4'h0, tm_q};
        end else if (a >= `AODT_REG_USER_FIRST && a <= `AODT_REG_USER_LAST) begin
            r = user_q[3'(a - `AODT_REG_USER_FIRST)];
        end else if (a >= `AODT_REG_THR_FIRST && a <= `AODT_REG_THR_LAST) begin
            r = a[0] ? thr_q[a[2:1]][15:8] : thr_q[a[2:1]][7:0];
        end else if (a == `AODT_REG_CAL_CTRL) begin
            r = {7'h00, gate_q};
        end else if (a == `AODT_REG_OUT_FMT) begin
            r = {7'h00, fmt_q};
        end else if (a == `AODT_REG_STATUS) begin
            r = {6'h00, ok_q, cfg.over_range_flag};
        end else if (a == `AODT_REG_CAL_COUNT) begin
            r = ucnt_q;
        end
        return r;
    endfunction : rd_byte

    // serial port sequencing
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        addr_d = addr_q;
        rd_d = rd_q;
        tx_d = tx_q;
        sdo_d = sdo_q;
        oe_n_d = oe_n_q;
        we = 1'b0;
        wdat = 8'h00;
        case (st_q)
            aodt_pkg::AODT_SPI_IDLE: begin
                cnt_d = 5'h00;
                if (!cs_s) begin
                    st_d = aodt_pkg::AODT_SPI_CMD;
                end
            end
            aodt_pkg::AODT_SPI_CMD: begin
                if (sck_rise) begin
                    sh_d = {sh_q[14:0], sdi_s};
                    cnt_d = 5'(cnt_q + 5'h01);
                    if (cnt_q == `AODT_SPI_CMD_LAST) begin
                        rd_d = sh_q[14];
                        addr_d = {sh_q[11:0], sdi_s};
                        tx_d = rd_byte({sh_q[11:0], sdi_s});
                        cnt_d = 5'h00;
                        st_d = aodt_pkg::AODT_SPI_DATA;
                    end
                end
            end
            aodt_pkg::AODT_SPI_DATA: begin
                if (sck_fall && rd_q) begin
                    sdo_d = tx_q[7];
                    tx_d = {tx_q[6:0], 1'b0};
                    oe_n_d = 1'b0;
                end
                if (sck_rise) begin
                    sh_d = {sh_q[14:0], sdi_s};
                    cnt_d = 5'(cnt_q + 5'h01);
                    if (cnt_q == `AODT_SPI_DATA_LAST) begin
                        we = !rd_q;
                        wdat = {sh_q[6:0], sdi_s};
                        st_d = aodt_pkg::AODT_SPI_END;
                    end
                end
            end
            aodt_pkg::AODT_SPI_END: st_d = aodt_pkg::AODT_SPI_END;
            default: st_d = aodt_pkg::AODT_SPI_IDLE;
        endcase
        if (cs_s) begin
            st_d = aodt_pkg::AODT_SPI_IDLE;
            oe_n_d = 1'b1;
            we = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= aodt_pkg::AODT_SPI_IDLE;
            cnt_q <= 5'h00;
            sh_q <= 16'h0000;
            addr_q <= 13'h0000;
            rd_q <= 1'b0;
            tx_q <= 8'h00;
            sdo_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
            tx_q <= tx_d;
            sdo_q <= sdo_d;
            oe_n_q <= oe_n_d;
        end
    end

    // register writes; a high threshold byte commits the pending low byte
    always_comb begin
        tm_d = tm_q;
        user_d = user_q;
        thr_d = thr_q;
        pend_d = pend_q;
        gate_d = gate_q;
        fmt_d = fmt_q;
        if (we) begin
            if (addr_q == `AODT_REG_TEST_MODE) begin
                tm_d = wdat[3:0];
            end else if (addr_q >= `AODT_REG_USER_FIRST && addr_q <= `AODT_REG_USER_LAST) begin
                user_d[3'(addr_q - `AODT_REG_USER_FIRST)] = wdat;
            end else if (addr_q >= `AODT_REG_THR_FIRST && addr_q <= `AODT_REG_THR_LAST) begin
                if (addr_q[0]) begin
                    thr_d[addr_q[2:1]] = {wdat, pend_q[addr_q[2:1]]};
                end else begin
                    pend_d[addr_q[2:1]] = wdat;
                end
            end else if (addr_q == `AODT_REG_CAL_CTRL) begin
                gate_d = wdat[`AODT_CAL_GATE_BIT];
            end else if (addr_q == `AODT_REG_OUT_FMT) begin
                fmt_d = wdat[`AODT_OUT_FMT_BIT];
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tm_q <= `AODT_TEST_MODE_RST;
            user_q <= '{default: 8'h00};
            thr_q <= '{default: 16'h0000};
            pend_q <= '{default: 8'h00};
            gate_q <= `AODT_CAL_GATE_RST;
            fmt_q <= 1'b0;
        end else begin
            tm_q <= tm_d;
            user_q <= user_d;
            thr_q <= thr_d;
            pend_q <= pend_d;
            gate_q <= gate_d;
            fmt_q <= fmt_d;
        end
    end

    // configuration to the datapath parts
    assign cfg.test_mode = tm_q;
    assign cfg.offset_bin = fmt_q;
    assign cfg.upper_thr = thr_q[`AODT_THR_UPPER];
    assign cfg.lower_thr = thr_q[`AODT_THR_LOWER];
    assign cfg.dwell = thr_q[`AODT_THR_DWELL];
    for (genvar k = 0; k < 4; k++) begin : g_user
        assign cfg.user_word[k] = {user_q[2 * k + 1], user_q[2 * k][7:4]};
    end

    // calibration magnitude average and update gate
    assign mag = sample_q[11] ? 12'(~sample_q + 12'h001) : sample_q;
    assign acc_sum = 22'(acc_q + {10'h000, mag});
    assign avg = 16'(acc_sum >> `AODT_CAL_AVG_SHIFT);

    always_comb begin
        ccnt_d = 10'(ccnt_q + 10'h001);
        acc_d = acc_sum;
        upd_d = 1'b0;
        ok_d = ok_q;
        ucnt_d = ucnt_q;
        if (ccnt_q == `AODT_CAL_LAST) begin
            acc_d = 22'h000000;
            upd_d = !gate_q || (avg > thr_q[`AODT_THR_CAL]);
            ok_d = upd_d;
            ucnt_d = 8'(ucnt_q + {7'h00, upd_d});
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            acc_q <= 22'h000000;
            ccnt_q <= 10'h000;
            upd_q <= 1'b0;
            ok_q <= 1'b0;
            ucnt_q <= 8'h00;
        end else begin
            acc_q <= acc_d;
            ccnt_q <= ccnt_d;
            upd_q <= upd_d;
            ok_q <= ok_d;
            ucnt_q <= ucnt_d;
        end
    end

    aodt_fdet u_fdet (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .sample(sample_q),
        .cfg(cfg.fdet)
    );

    aodt_pattern u_pattern (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .sample(sample_q),
        .cfg(cfg.pat),
        .data_out(DATA_OUT)
    );

    // outputs straight from flops
    assign SDIO_O = sdo_q;
    assign SDIO_OE_N = oe_n_q;
    assign OVER_RANGE_FLAG = cfg.over_range_flag;
    assign CAL_UPDATE = upd_q;

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    sample_take_a: assert property (##1 sample_q == $past(SAMPLE_IN)) else $error("sample not taken");
    acc_sum_a: assert property (ccnt_q != `AODT_CAL_LAST |=> acc_q == $past(acc_q) + $past(mag))
        else $error("magnitude not accumulated");
    cal_gate_a: assert property (ccnt_q == `AODT_CAL_LAST && gate_q && avg <= thr_q[`AODT_THR_CAL]
        |=> !CAL_UPDATE) else $error("update below threshold");
    cal_pass_a: assert property (ccnt_q == `AODT_CAL_LAST && avg > thr_q[`AODT_THR_CAL]
        |=> CAL_UPDATE ##1 !CAL_UPDATE) else $error("update missing");
    gate_hold_a: assert property ($fell(gate_q) |-> $past(we && addr_q == `AODT_REG_CAL_CTRL))
        else $error("gate changed without write");
    thr_pair_a: assert property (we && addr_q[0] && addr_q >= `AODT_REG_THR_FIRST &&
        addr_q <= `AODT_REG_THR_LAST |=> thr_q[$past(addr_q[2:1])] == {$past(wdat), $past(pend_q[addr_q[2:1]])})
        else $error("threshold pair not assembled");
    avg_range_a: assert property (avg <= `AODT_CAL_FULL) else $error("average beyond full scale");
endmodule : aodt_top
`default_nettype wire

// [core/aodt_cfg_if_note_removed.sv]
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// [tb/aodt_link_rx.sv]
// Purpose: link receiver model that takes one output word per clock
// Assumes: words arrive on the rising core clock edge
// Notes: keeps the latest two words so the bench can compare neighbours
`timescale 1ns/100ps
`default_nettype none
module aodt_link_rx (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] word,
    output logic [11:0] cur_q,
    output logic [11:0] prev_q
);
    // capture every word; the receiver never stalls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_q <= 12'h000;
            prev_q <= 12'h000;
        end else begin
            cur_q <= word;
            prev_q <= cur_q;
        end
    end
endmodule : aodt_link_rx
`default_nettype wire

// [tb/adc_output_detect_and_test_bench.sv]
// Purpose: self-checking bench for the output detect/test block
// Assumes: serial clock levels held four core clocks
// Notes: random samples from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module adc_output_detect_and_test_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] smp = 12'h000;
    logic cs_n = 1'b1;
    logic sclk = 1'b0;
    logic sdi = 1'b0;
    logic sdo, sdo_oe_n, flag, cal_up;
    logic [11:0] dout, cur, prv, h1;
    logic [11:0] uw [4];
    logic [3:0] codes [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
    logic [23:0] pp;
    logic [7:0] rb;
    int mismatches = 0;
    int num_checks = 0;
    int n;
    // shared data pin: device drives while its enable is low
    wire sdio = sdo_oe_n ? sdi : sdo;
    // core clock
    initial forever #5 clk = ~clk;
    aodt_top dut (.CORE_CLK(clk), .RST_N(rst_n), .SAMPLE_IN(smp), .SPI_CS_N(cs_n),
        .SPI_SCLK(sclk), .SDIO_I(sdio), .SDIO_O(sdo), .SDIO_OE_N(sdo_oe_n),
        .OVER_RANGE_FLAG(flag), .DATA_OUT(dout), .CAL_UPDATE(cal_up));
    aodt_link_rx rx (.clk(clk), .rst_n(rst_n), .word(dout), .cur_q(cur), .prev_q(prv));
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one framed byte: read flag, address, data, msb first
    task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] d);
        logic [23:0] f;
        f = {rd, 2'b00, a, d};
        cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi = f[i];
            tick(4);
            if (i < 8) rb[i] = sdio;
            sclk = 1'b1;
            tick(4);
            sclk = 1'b0;
        end
        tick(4);
        cs_n = 1'b1;
        tick(6);
    endtask : xfer
    // expected word pair of a fixed or alternating pattern
    function automatic logic [23:0] pat_pair(input logic [3:0] m);
        case (m)
            4'h1: return 24'h000000;
            4'h2: return 24'h7ff7ff;
            4'h3: return 24'h800800;
            4'h4: return 24'haaa555;
            default: return 24'hfff000;
        endcase
    endfunction : pat_pair
    // output must follow the sample of the previous slot
    task automatic pass_chk;
        h1 = smp;
        repeat (30) begin
            smp = 12'($urandom);
            tick(1);
            chk(dout, h1);
            h1 = smp;
        end
    endtask : pass_chk
    // count update pulses over the second of two windows
    task automatic cal_win(input logic [11:0] m, input logic exp);
        n = 0;
        for (int i = 0; i < 2200; i++) begin
            smp = $urandom_range(1) ? m : 12'(-m);
            tick(1);
            if (i > 1100 && cal_up === 1'b1) n++;
        end
        chk(n > 0, exp);
    endtask : cal_win
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // watchdog
    initial begin
        #400000;
        mismatches++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        void'($urandom(48));
        tick(3);
        chk({dout, flag, cal_up, sdo_oe_n}, 16'h0001);
        rst_n = 1'b1;
        tick(2);
        xfer(1'b1, 13'h00d, 8'h00);
        chk(rb, 8'h00);
        xfer(1'b1, 13'h108, 8'h00);
        chk(rb[0], 1'b1);
        pass_chk();
        $display("defaults and pass-through done");
        for (int f = 0; f < 2; f++) begin
            xfer(1'b0, 13'h109, 8'(f));
            foreach (codes[k]) begin
                xfer(1'b0, 13'h00d, {4'h0, codes[k]});
                pp = pat_pair(codes[k]) ^ ((codes[k] < 4) ? {f[0], 11'h0, f[0], 11'h0} : 24'h0);
                for (int i = 0; i < 6; i++) begin
                    tick(1);
                    chk(cur, (prv === pp[23:12]) ? pp[11:0] : pp[23:12]);
                end
            end
            for (int k = 0; k < 4; k++) begin
                uw[k] = {8'($urandom), 4'(k)};
                xfer(1'b0, 13'(13'h019 + 2 * k), {uw[k][3:0], 4'h0});
                xfer(1'b0, 13'(13'h01a + 2 * k), uw[k][11:4]);
            end
            xfer(1'b0, 13'h00d, 8'h08);
            for (int i = 0; i < 8; i++) begin
                tick(1);
                chk(cur, uw[prv[1:0] + 2'd1] ^ {f[0], 11'h0});
            end
        end
        xfer(1'b0, 13'h00d, 8'h0f);
        repeat (4100) begin
            tick(1);
            chk(cur, 12'(prv + 12'h001));
        end
        xfer(1'b0, 13'h00d, 8'h05);
        n = 0;
        repeat (40) begin
            tick(1);
            if (cur === prv) n++;
        end
        chk(n < 4, 1'b1);
        xfer(1'b0, 13'h109, 8'h00);
        xfer(1'b0, 13'h00d, 8'h06);
        pass_chk();
        $display("test patterns done");
        // low byte first; a pair commits on its high byte only
        xfer(1'b0, 13'h100, 8'h00);
        xfer(1'b0, 13'h101, 8'h20);
        xfer(1'b0, 13'h103, 8'h10);
        xfer(1'b0, 13'h104, 8'h03);
        xfer(1'b0, 13'h105, 8'h00);
        smp = 12'd1500;
        tick(3);
        chk(flag, 1'b1);
        // dwell of 3: the flag drops on the fourth below-lower sample
        smp = 12'hf9c;
        tick(4);
        chk(flag, 1'b1);
        tick(1);
        chk(flag, 1'b0);
        smp = 12'(-1500);
        tick(3);
        chk(flag, 1'b1);
        $display("over-range done");
        xfer(1'b0, 13'h107, 8'h40);
        cal_win(12'h7ff, 1'b0);
        xfer(1'b0, 13'h107, 8'h10);
        cal_win(12'd1024, 1'b1);
        xfer(1'b0, 13'h107, 8'h40);
        xfer(1'b0, 13'h108, 8'h00);
        cal_win(12'h7ff, 1'b1);
        $display("calibration gate done");
        tally_and_finish();
    end
endmodule : adc_output_detect_and_test_bench
`default_nettype wire
